// ---- core/eeb_pkg.sv ----
// Functional notes
// - write bit7 data, bit0 clock; read bit7
// - words are refused until write enable seen
// - enable stays until the disable sequence or a reset
// - disable is opcode 00, address top two bits zero
// - sixteen port reads return the word bits
// - first read gives msb, then lower bits
package eeb_pkg;

  // =========================================================
  // port byte layout
  localparam int          DATA_BIT   = 7;
  localparam int          SCLK_BIT   = 0;
  localparam logic [7:0]  END_BYTE   = 8'h00;
  localparam logic [7:0]  RD_RESET   = 8'h00;

  // =========================================================
  // reset stretch; host cycles the link side stays in reset
  localparam logic [6:0]  RST_HOLD   = 7'h60;

  // =========================================================
  // serial command layout
  localparam int          ADDR_W     = 6;
  localparam int          WORD_W     = 16;
  localparam int          CNT_W      = 4;
  localparam logic [3:0]  OPC_LAST   = 4'h1;
  localparam logic [3:0]  ADDR_LAST  = 4'h5;
  localparam logic [3:0]  WORD_LAST  = 4'hF;
  localparam logic [1:0]  OPC_CTRL   = 2'h0;
  localparam logic [1:0]  OPC_WRITE  = 2'h1;
  localparam logic [1:0]  OPC_READ   = 2'h2;
  localparam logic [1:0]  CTRL_WREN  = 2'h3;
  localparam logic [1:0]  CTRL_WDIS  = 2'h0;

  // =========================================================
  // serial engine states
  typedef enum logic [2:0] {
    EEB_IDLE,
    EEB_OPC,
    EEB_ADDR,
    EEB_DATA,
    EEB_RDOUT,
    EEB_DONE
  } eeb_state_t;

endpackage : eeb_pkg

// ---- core/eeb_sync.sv ----
// =========================================================
// three-stage synchroniser; output moves once stages two and
// three agree, so a single-cycle glitch never gets through
module eeb_sync #(
  parameter int          W    = 1,
  parameter logic [0:0]  INIT = 1'b0
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;
  logic [W-1:0] q_q;

  always_comb begin
    q_d = q_q;
    if (s2_q == s3_q) begin
      q_d = s3_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= {W{INIT}};
      s2_q <= {W{INIT}};
      s3_q <= {W{INIT}};
      q_q  <= {W{INIT}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end

  assign q = q_q;

endmodule : eeb_sync

// ---- core/eeb_port.sv ----
// =========================================================
// byte-wide bit-banged port to a serial calibration store.
// host side runs on clk; the serial engine and its word array
// run on link_clk. each taken port access is one event handed
// across by a toggle handshake; the byte and kind stay frozen
// until the link side echoes the toggle back.
module eeb_port (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        link_clk,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  output logic      [7:0]  rd_data,
  output logic             port_ready,
  output logic             write_enabled
);

  // =========================================================
  // host domain
  logic       req_q;
  logic       req_d;
  logic [7:0] ev_byte_q;
  logic [7:0] ev_byte_d;
  logic       ev_read_q;
  logic       ev_read_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       ack_s;
  logic       dout_s;
  logic       wen_s;
  logic       take_wr;
  logic       take_rd;
  // a short host reset pulse would slip past the slow link
  // clock, so the host stretches it before handing it across
  logic       lrst_q;
  logic       lrst_d;
  logic [6:0] hold_q;
  logic [6:0] hold_d;
  logic       hrst;

  // a new access waits until the last one has been echoed, and
  // until the host side's reset stretch (lrst_q) has run out
  assign port_ready = (req_q == ack_s) && !lrst_q;
  assign hrst       = srst || lrst_q;
  assign take_wr    = ce && wr_en && port_ready;
  assign take_rd    = ce && rd_en && !wr_en && port_ready;

  always_comb begin
    req_d     = req_q;
    hold_d    = hold_q;
    lrst_d    = (hold_q != 7'h00);
    if (hold_q != 7'h00) begin
      hold_d = hold_q - 7'h01;
    end
    ev_byte_d = ev_byte_q;
    ev_read_d = ev_read_q;
    rd_data_d = rd_data_q;
    if (take_wr) begin
      ev_byte_d = wr_data;
      ev_read_d = 1'b0;
      req_d     = !req_q;
    end else if (take_rd) begin
      rd_data_d           = eeb_pkg::RD_RESET;
      rd_data_d[eeb_pkg::DATA_BIT] = dout_s;
      ev_read_d           = 1'b1;
      req_d               = !req_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_q    <= eeb_pkg::RST_HOLD;
      lrst_q    <= 1'b1;
      req_q     <= 1'b0;
      ev_byte_q <= eeb_pkg::END_BYTE;
      ev_read_q <= 1'b0;
      rd_data_q <= eeb_pkg::RD_RESET;
    end else if (ce) begin
      req_q     <= req_d;
      ev_byte_q <= ev_byte_d;
      ev_read_q <= ev_read_d;
      rd_data_q <= rd_data_d;
      hold_q    <= hold_d;
      lrst_q    <= lrst_d;
    end
  end

  assign rd_data       = rd_data_q;
  assign write_enabled = wen_s;

  // =========================================================
  // crossings
  logic rst_l;
  logic ce_l;
  logic req_l;
  logic ack_q;
  logic dout_q;
  logic wen_q;

  eeb_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
    .clk (link_clk),
    .rst (1'b0),
    .d   (lrst_q),
    .q   (rst_l)
  );

  eeb_sync #(.W(1), .INIT(1'b0)) u_ce_sync (
    .clk (link_clk),
    .rst (rst_l),
    .d   (ce),
    .q   (ce_l)
  );

  eeb_sync #(.W(1), .INIT(1'b0)) u_req_sync (
    .clk (link_clk),
    .rst (rst_l),
    .d   (req_q),
    .q   (req_l)
  );

  eeb_sync #(.W(1), .INIT(1'b0)) u_ack_sync (
    .clk (clk),
    .rst (hrst),
    .d   (ack_q),
    .q   (ack_s)
  );

  eeb_sync #(.W(1), .INIT(1'b0)) u_dout_sync (
    .clk (clk),
    .rst (hrst),
    .d   (dout_q),
    .q   (dout_s)
  );

  eeb_sync #(.W(1), .INIT(1'b0)) u_wen_sync (
    .clk (clk),
    .rst (hrst),
    .d   (wen_q),
    .q   (wen_s)
  );

  // =========================================================
  // serial engine (link domain)
  localparam int DEPTH = 1 << eeb_pkg::ADDR_W;

  eeb_pkg::eeb_state_t          st_q;
  eeb_pkg::eeb_state_t          st_d;
  logic [eeb_pkg::CNT_W-1:0]    cnt_q;
  logic [eeb_pkg::CNT_W-1:0]    cnt_d;
  logic [1:0]                   opc_q;
  logic [1:0]                   opc_d;
  logic [eeb_pkg::ADDR_W-1:0]   addr_q;
  logic [eeb_pkg::ADDR_W-1:0]   addr_d;
  logic [eeb_pkg::ADDR_W-1:0]   addr_n;
  logic [eeb_pkg::WORD_W-1:0]   word_q;
  logic [eeb_pkg::WORD_W-1:0]   word_d;
  logic [eeb_pkg::WORD_W-1:0]   word_n;
  logic [eeb_pkg::WORD_W-1:0]   mem_rd;
  logic                         dout_d;
  logic                         wen_d;
  logic                         ack_d;
  logic                         ev;
  logic                         bit_in;
  logic                         mem_we;

  // words survive reset: the array stands for nonvolatile cells
  logic [eeb_pkg::WORD_W-1:0]   mem [DEPTH];

  assign ev     = ce_l && (req_l != ack_q);
  assign bit_in = ev_byte_q[eeb_pkg::DATA_BIT];
  assign addr_n = {addr_q[eeb_pkg::ADDR_W-2:0], bit_in};
  assign word_n = {word_q[eeb_pkg::WORD_W-2:0], bit_in};
  assign mem_rd = mem[addr_n];

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    opc_d  = opc_q;
    addr_d = addr_q;
    word_d = word_q;
    dout_d = dout_q;
    wen_d  = wen_q;
    ack_d  = ack_q;
    mem_we = 1'b0;
    if (ev) begin
      ack_d = req_l;
      if (ev_read_q) begin
        // each port read hands out one bit, msb first
        if (st_q == eeb_pkg::EEB_RDOUT) begin
          word_d = {word_q[eeb_pkg::WORD_W-2:0], 1'b0};
          dout_d = word_q[eeb_pkg::WORD_W-2];
          cnt_d  = cnt_q + 4'h1;
          if (cnt_q == eeb_pkg::WORD_LAST) begin
            st_d   = eeb_pkg::EEB_DONE;
            dout_d = 1'b0;
          end
        end
      end else if (ev_byte_q == eeb_pkg::END_BYTE) begin
        // deselect: any half-sent command is dropped
        st_d   = eeb_pkg::EEB_IDLE;
        cnt_d  = '0;
        dout_d = 1'b0;
      end else if (ev_byte_q[eeb_pkg::SCLK_BIT]) begin
        case (st_q)
          eeb_pkg::EEB_IDLE: begin
            if (bit_in) begin
              st_d  = eeb_pkg::EEB_OPC;
              cnt_d = '0;
            end
          end
          eeb_pkg::EEB_OPC: begin
            opc_d = {opc_q[0], bit_in};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == eeb_pkg::OPC_LAST) begin
              st_d  = eeb_pkg::EEB_ADDR;
              cnt_d = '0;
            end
          end
          eeb_pkg::EEB_ADDR: begin
            addr_d = addr_n;
            cnt_d  = cnt_q + 4'h1;
            if (cnt_q == eeb_pkg::ADDR_LAST) begin
              cnt_d = '0;
              case (opc_q)
                eeb_pkg::OPC_WRITE: begin
                  st_d = eeb_pkg::EEB_DATA;
                end
                eeb_pkg::OPC_READ: begin
                  // command complete after nine bits
                  word_d = mem_rd;
                  dout_d = mem_rd[eeb_pkg::WORD_W-1];
                  st_d   = eeb_pkg::EEB_RDOUT;
                end
                eeb_pkg::OPC_CTRL: begin
                  if (addr_n[5:4] == eeb_pkg::CTRL_WREN) begin
                    wen_d = 1'b1;
                  end else if (addr_n[5:4] ==
                               eeb_pkg::CTRL_WDIS) begin
                    wen_d = 1'b0;
                  end
                  st_d = eeb_pkg::EEB_DONE;
                end
                default: begin
                  st_d = eeb_pkg::EEB_DONE;
                end
              endcase
            end
          end
          eeb_pkg::EEB_DATA: begin
            word_d = word_n;
            cnt_d  = cnt_q + 4'h1;
            if (cnt_q == eeb_pkg::WORD_LAST) begin
              mem_we = wen_q;
              st_d   = eeb_pkg::EEB_DONE;
            end
          end
          // extra clocks after a read command or a finished one
          // are ignored until the deselect byte
          eeb_pkg::EEB_RDOUT: begin
            st_d = st_q;
          end
          eeb_pkg::EEB_DONE: begin
            st_d = st_q;
          end
          default: begin
            st_d = eeb_pkg::EEB_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      st_q   <= eeb_pkg::EEB_IDLE;
      cnt_q  <= '0;
      opc_q  <= eeb_pkg::OPC_CTRL;
      addr_q <= '0;
      word_q <= '0;
      dout_q <= 1'b0;
      wen_q  <= 1'b0;
      ack_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      opc_q  <= opc_d;
      addr_q <= addr_d;
      word_q <= word_d;
      dout_q <= dout_d;
      wen_q  <= wen_d;
      ack_q  <= ack_d;
    end
  end

  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[addr_q] <= word_n;
    end
  end

endmodule : eeb_port

// ---- tb/eeb_sva.sv ----
// ====
// port checker
module eeb_sva (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       link_clk,
  input wire logic       wr_en,
  input wire logic [7:0] wr_data,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       port_ready,
  input wire logic       write_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       tk, tk_rd, dsl_q, dsl_d;
  logic [7:0] idl_q, idl_d;
  assign tk    = ce && port_ready && (wr_en || rd_en);
  assign tk_rd = tk && !wr_en;
  always_comb begin
    idl_d = tk ? 8'h00 : idl_q + {7'h00, idl_q != 8'hFF};
    dsl_d = (tk && wr_en) ? wr_data == 8'h00 : dsl_q;
  end
  always_ff @(posedge clk) begin
    idl_q <= srst ? 8'h00 : idl_d;
    dsl_q <= srst ? 1'b0 : dsl_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RD_LOW: assert property (rd_data[6:0] == 7'h00)
    else $error("rd low bits");
  AST_TAKE: assert property (tk |=> !port_ready)
    else $error("take ignored");
  AST_BUSY: assert property ($fell(port_ready) |-> !port_ready [*4])
    else $error("ready early");
  AST_BACK: assert property ($fell(port_ready) |-> ##[1:300] port_ready)
    else $error("ready stuck");
  AST_HOLD: assert property (port_ready && !tk |=> port_ready)
    else $error("ready fell");
  AST_RD_KEEP: assert property (!tk_rd && !$past(tk_rd) |=> $stable(rd_data))
    else $error("rd moved");
  AST_WE_KEEP: assert property (idl_q == 8'hFF |-> $stable(write_enabled))
    else $error("we moved");
  AST_DESEL: assert property (tk_rd && dsl_q |-> ##2 rd_data == 8'h00)
    else $error("idle read");
  AST_RST_OUT: assert property ($fell(srst) |-> !write_enabled && !port_ready)
    else $error("reset outputs");
endmodule : eeb_sva

bind eeb_port eeb_sva u_sva (.clk(clk), .srst(srst), .ce(ce),
  .link_clk(link_clk), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
  .rd_data(rd_data), .port_ready(port_ready),
  .write_enabled(write_enabled));

// ---- tb/eeb_host.sv ----
// ====
// host model; one access at a time, each awaits port_ready
module eeb_host (
  input  wire logic       clk,
  input  wire logic       port_ready,
  input  wire logic [7:0] rd_data,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  bit hung = 1'b0;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 8'h00;
  end
  task automatic rdy();
    int n;
    n = 0;
    while (!port_ready && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) hung = 1'b1;
  endtask : rdy
  task automatic xfer(input bit w, input logic [7:0] b,
                      output logic [7:0] r);
    @(negedge clk);
    rdy();
    wr_en = w;
    rd_en = !w;
    wr_data = b;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b0;
    rdy();
    r = rd_data;
  endtask : xfer
  task automatic put(input logic [7:0] b);
    logic [7:0] r;
    xfer(1'b1, b, r);
  endtask : put
  task automatic bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) put({v[i], 6'h00, 1'b1});
  endtask : bits
  task automatic cmd(input logic [1:0] op, input logic [5:0] a);
    put(8'h81);
    bits({14'h0, op}, 2);
    bits({10'h0, a}, 6);
  endtask : cmd
  task automatic wr_word(input logic [5:0] a, input logic [15:0] d);
    cmd(2'h1, a);
    bits(d, 16);
    put(8'h00);
  endtask : wr_word
  task automatic ctrl(input bit en);
    cmd(2'h0, en ? 6'h30 : 6'h00);
    put(8'h00);
  endtask : ctrl
  task automatic rd_word(input logic [5:0] a, input bit extra,
                         output logic [15:0] d);
    logic [7:0] r;
    cmd(2'h2, a);
    if (extra) put(8'h01);
    for (int i = 15; i >= 0; i--) begin
      xfer(1'b0, 8'h00, r);
      d[i] = r[7];
    end
    put(8'h00);
  endtask : rd_word
endmodule : eeb_host

// ---- tb/tb_eeprom_bitbang_port.sv ----
module tb_eeprom_bitbang_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, link_clk = 0, srst = 1, ce = 1;
  logic        wr_en, rd_en, port_ready, write_enabled;
  logic [7:0]  wr_data, rd_data, r;
  logic [31:0] seed = 32'hD2D7CA3D;
  logic [5:0]  a [4];
  logic [15:0] d [4];
  logic [15:0] got;
  int          n_fail = 0, checked = 0;
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
  initial forever #4 clk = ~clk;
  initial begin
    #3;
    forever #32 link_clk = ~link_clk;
  end
  eeb_port u_dut (.clk(clk), .srst(srst), .ce(ce), .link_clk(link_clk),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
    .port_ready(port_ready), .write_enabled(write_enabled));
  eeb_host h (.clk(clk), .port_ready(port_ready), .rd_data(rd_data),
    .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic finish_test();
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  always @(posedge h.hung) begin
    n_fail++;
    finish_test();
  end
  // ====
  // main sequence; the port stretches reset for the link side
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (64) @(negedge clk);
    `CHK("rdy", 1'b0, port_ready)
    `CHK("rd", 8'h00, rd_data)
    `CHK("we", 1'b0, write_enabled)
    void'(rnd());
    a = '{6'h00, 6'h3F, {2'h1, seed[3:0]}, {2'h2, seed[9:6]}};
    void'(rnd());
    d = '{16'hFFFF, 16'h0000, seed[31:16], seed[15:0]};
    h.ctrl(1'b1);
    repeat (300) @(negedge clk);
    `CHK("we", 1'b1, write_enabled)
    for (int i = 0; i < 4; i++) h.wr_word(a[i], d[i]);
    for (int i = 0; i < 4; i++) begin
      h.rd_word(a[i], i[0], got);
      `CHK("word", d[i], got)
    end
    h.ctrl(1'b0);
    repeat (24) @(negedge clk);
    `CHK("we", 1'b0, write_enabled)
    h.wr_word(a[2], ~d[2]);
    h.rd_word(a[2], 1'b0, got);
    `CHK("locked", d[2], got)
    h.ctrl(1'b1);
    h.cmd(2'h1, a[3]);
    h.bits({8'h00, ~d[3][15:8]}, 8);
    h.put(8'h00);
    h.xfer(1'b0, 8'h00, r);
    `CHK("idle", 8'h00, r)
    h.rd_word(a[3], 1'b0, got);
    `CHK("abort", d[3], got)
    // mid-run reset: latch clears, stored words stay
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    `CHK("we", 1'b0, write_enabled)
    h.wr_word(a[1], ~d[1]);
    h.rd_word(a[1], 1'b0, got);
    `CHK("kept", d[1], got)
    finish_test();
  end
endmodule : tb_eeprom_bitbang_port
